// [logic/rpf_pkg.sv]
// Constants and types shared by the packet format configuration block
`default_nettype none
package rpf_pkg;
   // Register byte offsets
   localparam int           ADDR_W       = 12;
   localparam logic [11:0]  PKT_CFG0_OFS = 12'h514;
   localparam logic [11:0]  PKT_CFG1_OFS = 12'h518;
   localparam logic [11:0]  BASE0_OFS    = 12'h51C;
   localparam logic [11:0]  BASE_ADDRESS_1_OFS    = 12'h520;
   localparam logic [11:0]  PFX_LO_OFS   = 12'h524;
   localparam logic [11:0]  PFX_HI_OFS   = 12'h528;
   // Register indexes inside the bank
   localparam logic [2:0]   IDX_CFG0     = 3'h0;
   localparam logic [2:0]   IDX_CFG1     = 3'h1;
   localparam logic [2:0]   IDX_BASE0    = 3'h2;
   localparam logic [2:0]   IDX_BASE_ADDRESS_1    = 3'h3;
   localparam logic [2:0]   IDX_PFX_LO   = 3'h4;
   localparam logic [2:0]   IDX_PFX_HI   = 3'h5;
   localparam logic [2:0]   IDX_NONE     = 3'h7;
   // Reset value of every register
   localparam logic [31:0]  REG_RESET    = 32'h00000000;
   // Packet config 0 fields
   localparam int           LEN_BITS_LSB = 0;
   localparam int           HDR0_BIT     = 8;
   localparam int           HDR1_BITS_LSB = 16;
   localparam logic [31:0]  CFG0_MASK    = 32'h000F010F;
   // Packet config 1 fields
   localparam int           MAX_PAY_LSB  = 0;
   localparam int           EXTRA_LEN_LSB = 8;
   localparam int           BASE_BYTES_LSB = 16;
   localparam int           ORDER_BIT    = 24;
   localparam logic [31:0]  CFG1_MASK    = 32'h0107FFFF;
   // Base address length limits
   localparam logic [2:0]   BASE_BYTES_MIN = 3'h2;
   localparam logic [2:0]   BASE_BYTES_MAX = 3'h4;
   // AXI responses
   localparam logic [1:0]   RESP_OKAY    = 2'h0;
   localparam logic [1:0]   RESP_SLVERR  = 2'h2;
   // Transmit field sequencer, one-hot
   typedef enum logic [6:0] {
      TX_IDLE = 7'h01,
      TX_ADDR = 7'h02,
      TX_HDR0 = 7'h04,
      TX_LEN  = 7'h08,
      TX_HDR1 = 7'h10,
      TX_PAY  = 7'h20,
      TX_DONE = 7'h40
   } rpf_tx_state_t;
endpackage
`default_nettype wire

// [logic/rpf_bit_shifter.sv]
// Field serialiser: shifts up to eight bits out in either bit order
`timescale 1ns/1ps
`default_nettype none
module rpf_bit_shifter
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       load_i,
   input  wire logic [7:0] data_i,
   input  wire logic [3:0] nbits_i,
   input  wire logic       msb_first_i,
   input  wire logic       bit_ready_i,
   output logic            idle_o,
   output logic            bit_o,
   output logic            bit_valid_o
);
   // All state in one word
   typedef struct packed {
      logic [7:0] sh;     // Bits still to go
      logic [3:0] left;   // Count of bits still to go
      logic       msb;    // Order of this field
   } rpf_shift_t;

   rpf_shift_t s_reg;
   rpf_shift_t s_next;

   // Load aligns the first bit to the end it leaves from
   always_comb
   begin
      s_next = s_reg;
      if (load_i && s_reg.left == 4'h0)
      begin
         s_next.msb  = msb_first_i;
         s_next.left = nbits_i;
         // MSB first: top of field moved to bit 7
         s_next.sh   = msb_first_i ? 8'(data_i << (4'h8 - nbits_i))
                                   : data_i; // R4
      end
      else if (s_reg.left != 4'h0 && bit_ready_i)
      begin
         // One bit leaves per accepted cycle
         s_next.left = s_reg.left - 4'h1;
         s_next.sh   = s_reg.msb ? {s_reg.sh[6:0], 1'b0}
                                 : {1'b0, s_reg.sh[7:1]}; // R4
      end
   end

   // State register
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end

   assign idle_o      = (s_reg.left == 4'h0);
   assign bit_valid_o = (s_reg.left != 4'h0);
   assign bit_o       = s_reg.msb ? s_reg.sh[7] : s_reg.sh[0];

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_lsb_first_bit: assert property ( // R4
      (load_i && idle_o && !msb_first_i && nbits_i != 4'h0)
      |=> (bit_o == $past(data_i[0])))
      else $error("LSB-first field did not start with bit 0");
   a_msb_first_bit: assert property ( // R4
      (load_i && idle_o && msb_first_i && nbits_i == 4'h8)
      |=> (bit_o == $past(data_i[7])))
      else $error("MSB-first byte did not start with bit 7");
endmodule
`default_nettype wire

// [logic/rpf_packet_format.sv]
// Packet format registers, transmit field framer and receive length logic
//
// Summary of operation
// R1: Payload cut to maximum length, both directions
// R2: Static extra bytes added to length field
// R3: Address is base bytes then one prefix
// R4: Bit order covers headers, length and payload
// R5: Low prefix register lanes hold addresses 0-3
// R6: High prefix register lanes hold addresses 4-7
// R7: Frame: address bytes, header0, length, header1, payload
`timescale 1ns/1ps
`default_nettype none
module rpf_packet_format
(
   input  wire logic        REF_CLK_I,
   input  wire logic        RST_I,
   // AXI4-Lite slave
   input  wire logic [11:0] S_AXI_AWADDR_I,
   input  wire logic        S_AXI_AWVALID_I,
   output logic             S_AXI_AWREADY_O,
   input  wire logic [31:0] S_AXI_WDATA_I,
   input  wire logic [3:0]  S_AXI_WSTRB_I,
   input  wire logic        S_AXI_WVALID_I,
   output logic             S_AXI_WREADY_O,
   output logic [1:0]       S_AXI_BRESP_O,
   output logic             S_AXI_BVALID_O,
   input  wire logic        S_AXI_BREADY_I,
   input  wire logic [11:0] S_AXI_ARADDR_I,
   input  wire logic        S_AXI_ARVALID_I,
   output logic             S_AXI_ARREADY_O,
   output logic [31:0]      S_AXI_RDATA_O,
   output logic [1:0]       S_AXI_RRESP_O,
   output logic             S_AXI_RVALID_O,
   input  wire logic        S_AXI_RREADY_I,
   // Transmit frame request
   input  wire logic        TX_START_I,
   input  wire logic [2:0]  TX_LADDR_I,
   input  wire logic [7:0]  TX_HDR0_I,
   input  wire logic [7:0]  TX_LEN_I,
   input  wire logic [7:0]  TX_HDR1_I,
   output logic             TX_BUSY_O,
   // Payload byte stream in
   input  wire logic [7:0]  PAY_DATA_I,
   input  wire logic        PAY_VALID_I,
   output logic             PAY_READY_O,
   // On-air bit stream out
   output logic             BIT_O,
   output logic             BIT_VALID_O,
   input  wire logic        BIT_READY_I,
   // Receive side settings
   input  wire logic [7:0]  RX_LEN_I,
   input  wire logic [2:0]  RX_LADDR_I,
   output logic [7:0]       RX_PAY_LEN_O,
   output logic [39:0]      RX_ADDR_O,
   output logic [2:0]       RX_ADDR_BYTES_O,
   output logic             RX_MSB_FIRST_O
);
   // Whole module state
   typedef struct packed {
      logic                   aw_got;   // Write address held
      logic [11:0]            aw_addr;
      logic                   w_got;    // Write data held
      logic [31:0]            w_data;
      logic [3:0]             w_strb;
      logic                   b_valid;
      logic [1:0]             b_resp;
      logic                   r_valid;
      logic [31:0]            r_data;
      logic [1:0]             r_resp;
      logic [5:0][31:0]       regs;     // Register bank
      rpf_pkg::rpf_tx_state_t st;
      logic [2:0]             k;        // Address byte index
      logic [7:0]             cnt;      // Payload bytes sent
      logic [7:0]             eff;      // Payload bytes due
      logic [7:0]             hdr0;
      logic [7:0]             len;
      logic [7:0]             hdr1;
      logic [2:0]             laddr;
      logic [7:0]             rx_len;   // Receive payload length
      logic [39:0]            rx_addr;
      logic [2:0]             rx_abytes;
   } rpf_state_t;

   rpf_state_t s_reg;
   rpf_state_t s_next;

   // Serialiser hookup
   logic       ser_idle;
   logic       ser_load;
   logic [7:0] ser_data;
   logic [3:0] ser_nbits;
   logic       ser_msb;

   // Decoded configuration
   logic [7:0] max_len;
   logic [7:0] stat_len;
   logic [2:0] base_bytes;
   logic       msb_first;
   logic       hdr0_on;
   logic [3:0] len_bits;
   logic [3:0] hdr1_bits;

   // Byte offset to register index
   function automatic logic [2:0] reg_index(input logic [11:0] a);
      unique case (a)
         rpf_pkg::PKT_CFG0_OFS: reg_index = rpf_pkg::IDX_CFG0;
         rpf_pkg::PKT_CFG1_OFS: reg_index = rpf_pkg::IDX_CFG1;
         rpf_pkg::BASE0_OFS:    reg_index = rpf_pkg::IDX_BASE0;
         rpf_pkg::BASE_ADDRESS_1_OFS:    reg_index = rpf_pkg::IDX_BASE_ADDRESS_1;
         rpf_pkg::PFX_LO_OFS:   reg_index = rpf_pkg::IDX_PFX_LO;
         rpf_pkg::PFX_HI_OFS:   reg_index = rpf_pkg::IDX_PFX_HI;
         default:               reg_index = rpf_pkg::IDX_NONE;
      endcase
   endfunction

   // Writable bits of each register
   function automatic logic [31:0] reg_mask(input logic [2:0] i);
      if (i == rpf_pkg::IDX_CFG0)
         reg_mask = rpf_pkg::CFG0_MASK;
      else if (i == rpf_pkg::IDX_CFG1)
         reg_mask = rpf_pkg::CFG1_MASK;
      else
         reg_mask = 32'hFFFFFFFF;
   endfunction

   // Payload bytes: length plus extra, cut at maximum
   function automatic logic [7:0] eff_len(input logic [7:0] l,
                                          input logic [7:0] st,
                                          input logic [7:0] mx);
      logic [8:0] sum;
      sum = {1'b0, l} + {1'b0, st}; // R2
      eff_len = (sum > {1'b0, mx}) ? mx : sum[7:0]; // R1
   endfunction

   // Prefix byte of a logical address
   function automatic logic [7:0] prefix_of(input rpf_state_t s,
                                            input logic [2:0] la);
      logic [31:0] w;
      w = la[2] ? s.regs[rpf_pkg::IDX_PFX_HI] // R6
                : s.regs[rpf_pkg::IDX_PFX_LO]; // R5
      prefix_of = w[{la[1:0], 3'h0} +: 8]; // R5
   endfunction

   // Base word of a logical address: 0 uses base 0, rest base 1
   function automatic logic [31:0] base_of(input rpf_state_t s,
                                           input logic [2:0] la);
      base_of = (la == 3'h0) ? s.regs[rpf_pkg::IDX_BASE0]
                             : s.regs[rpf_pkg::IDX_BASE_ADDRESS_1];
   endfunction

   // Field bits limited to one serialiser load
   function automatic logic [3:0] clip8(input logic [3:0] n);
      clip8 = (n > 4'h8) ? 4'h8 : n;
   endfunction

   // Configuration fields
   always_comb
   begin
      max_len   = s_reg.regs[rpf_pkg::IDX_CFG1][rpf_pkg::MAX_PAY_LSB +: 8];
      stat_len  = s_reg.regs[rpf_pkg::IDX_CFG1][rpf_pkg::EXTRA_LEN_LSB +: 8];
      base_bytes =
         s_reg.regs[rpf_pkg::IDX_CFG1][rpf_pkg::BASE_BYTES_LSB +: 3];
      // Illegal lengths pinned into range so address stays sane
      if (base_bytes < rpf_pkg::BASE_BYTES_MIN)
         base_bytes = rpf_pkg::BASE_BYTES_MIN;
      else if (base_bytes > rpf_pkg::BASE_BYTES_MAX)
         base_bytes = rpf_pkg::BASE_BYTES_MAX;
      msb_first = s_reg.regs[rpf_pkg::IDX_CFG1][rpf_pkg::ORDER_BIT];
      hdr0_on   = s_reg.regs[rpf_pkg::IDX_CFG0][rpf_pkg::HDR0_BIT];
      len_bits  = s_reg.regs[rpf_pkg::IDX_CFG0][rpf_pkg::LEN_BITS_LSB +: 4];
      hdr1_bits = s_reg.regs[rpf_pkg::IDX_CFG0][rpf_pkg::HDR1_BITS_LSB +: 4];
   end

   // Bus, framer and receive logic next state
   always_comb
   begin
      s_next    = s_reg;
      ser_load  = 1'b0;
      ser_data  = 8'h00;
      ser_nbits = 4'h0;
      ser_msb   = 1'b0;

      // Address and data taken in either order
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O)
      begin
         s_next.aw_got  = 1'b1;
         s_next.aw_addr = S_AXI_AWADDR_I;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O)
      begin
         s_next.w_got  = 1'b1;
         s_next.w_data = S_AXI_WDATA_I;
         s_next.w_strb = S_AXI_WSTRB_I;
      end
      // Write lands once both halves are held
      if (s_reg.aw_got && s_reg.w_got && !s_reg.b_valid)
      begin
         s_next.aw_got  = 1'b0;
         s_next.w_got   = 1'b0;
         s_next.b_valid = 1'b1;
         if (reg_index(s_reg.aw_addr) == rpf_pkg::IDX_NONE)
            s_next.b_resp = rpf_pkg::RESP_SLVERR;
         else
         begin
            s_next.b_resp = rpf_pkg::RESP_OKAY;
            for (int b = 0; b < 4; b++)
            begin
               if (s_reg.w_strb[b])
                  s_next.regs[reg_index(s_reg.aw_addr)][b*8 +: 8] =
                     s_reg.w_data[b*8 +: 8];
            end
            // Reserved bits kept at zero
            s_next.regs[reg_index(s_reg.aw_addr)] =
               s_next.regs[reg_index(s_reg.aw_addr)] &
               reg_mask(reg_index(s_reg.aw_addr));
         end
      end
      else if (s_reg.b_valid && S_AXI_BREADY_I)
         s_next.b_valid = 1'b0;

      // Read answered one cycle after address
      if (S_AXI_ARVALID_I && S_AXI_ARREADY_O)
      begin
         s_next.r_valid = 1'b1;
         if (reg_index(S_AXI_ARADDR_I) == rpf_pkg::IDX_NONE)
         begin
            s_next.r_data = 32'h00000000;
            s_next.r_resp = rpf_pkg::RESP_SLVERR;
         end
         else
         begin
            s_next.r_data = s_reg.regs[reg_index(S_AXI_ARADDR_I)];
            s_next.r_resp = rpf_pkg::RESP_OKAY;
         end
      end
      else if (s_reg.r_valid && S_AXI_RREADY_I)
         s_next.r_valid = 1'b0;

      // Receive side: payload count and expected address
      s_next.rx_len    = eff_len(RX_LEN_I, stat_len, max_len); // R1
      s_next.rx_addr   = {base_of(s_reg, RX_LADDR_I),
                          prefix_of(s_reg, RX_LADDR_I)}; // R3
      s_next.rx_abytes = base_bytes + 3'h1; // R3

      // Transmit field sequencer; loads only when serialiser is idle
      unique case (s_reg.st)
         rpf_pkg::TX_IDLE:
         begin
            if (TX_START_I)
            begin
               s_next.st    = rpf_pkg::TX_ADDR;
               s_next.k     = 3'h0;
               s_next.cnt   = 8'h00;
               s_next.hdr0  = TX_HDR0_I;
               s_next.len   = TX_LEN_I;
               s_next.hdr1  = TX_HDR1_I;
               s_next.laddr = TX_LADDR_I;
               s_next.eff   = eff_len(TX_LEN_I, stat_len, max_len); // R1
            end
         end
         rpf_pkg::TX_ADDR:
         begin
            if (ser_idle)
            begin
               // Base bytes first, prefix byte last
               ser_load  = 1'b1;
               ser_nbits = 4'h8;
               ser_data  = (s_reg.k < base_bytes)
                  ? 8'(base_of(s_reg, s_reg.laddr) >> {s_reg.k[1:0], 3'h0})
                  : prefix_of(s_reg, s_reg.laddr); // R3
               s_next.k  = s_reg.k + 3'h1;
               if (s_reg.k == base_bytes)
                  s_next.st = rpf_pkg::TX_HDR0; // R3
            end
         end
         rpf_pkg::TX_HDR0:
         begin
            // Zero-length fields pass with no load
            if (ser_idle)
            begin
               ser_load  = hdr0_on;
               ser_nbits = 4'h8;
               ser_data  = s_reg.hdr0;
               ser_msb   = msb_first; // R4
               s_next.st = rpf_pkg::TX_LEN; // R7
            end
         end
         rpf_pkg::TX_LEN:
         begin
            if (ser_idle)
            begin
               ser_load  = (len_bits != 4'h0);
               ser_nbits = clip8(len_bits);
               ser_data  = s_reg.len;
               ser_msb   = msb_first; // R4
               s_next.st = rpf_pkg::TX_HDR1; // R7
            end
         end
         rpf_pkg::TX_HDR1:
         begin
            if (ser_idle)
            begin
               ser_load  = (hdr1_bits != 4'h0);
               ser_nbits = clip8(hdr1_bits);
               ser_data  = s_reg.hdr1;
               ser_msb   = msb_first; // R4
               s_next.st = rpf_pkg::TX_PAY; // R7
            end
         end
         rpf_pkg::TX_PAY:
         begin
            // Only the due count is pulled from the source
            if (s_reg.cnt == s_reg.eff)
               s_next.st = rpf_pkg::TX_DONE; // R1
            else if (ser_idle && PAY_VALID_I)
            begin
               ser_load   = 1'b1;
               ser_nbits  = 4'h8;
               ser_data   = PAY_DATA_I;
               ser_msb    = msb_first; // R4
               s_next.cnt = s_reg.cnt + 8'h01;
            end
         end
         rpf_pkg::TX_DONE:
         begin
            // Frame ends once the last bit has left
            if (ser_idle)
               s_next.st = rpf_pkg::TX_IDLE;
         end
         default:
            s_next.st = rpf_pkg::TX_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge REF_CLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         s_reg    <= '0;
         s_reg.regs <= {6{rpf_pkg::REG_RESET}};
         s_reg.st <= rpf_pkg::TX_IDLE;
      end
      else
         s_reg <= s_next;
   end

   // Bit serialiser
   rpf_bit_shifter u_shift
   (
      .clk_i       (REF_CLK_I),
      .rst_i       (RST_I),
      .load_i      (ser_load),
      .data_i      (ser_data),
      .nbits_i     (ser_nbits),
      .msb_first_i (ser_msb),
      .bit_ready_i (BIT_READY_I),
      .idle_o      (ser_idle),
      .bit_o       (BIT_O),
      .bit_valid_o (BIT_VALID_O)
   );

   // Outputs
   assign S_AXI_AWREADY_O = !s_reg.aw_got;
   assign S_AXI_WREADY_O  = !s_reg.w_got;
   assign S_AXI_BVALID_O  = s_reg.b_valid;
   assign S_AXI_BRESP_O   = s_reg.b_resp;
   assign S_AXI_ARREADY_O = !s_reg.r_valid;
   assign S_AXI_RVALID_O  = s_reg.r_valid;
   assign S_AXI_RDATA_O   = s_reg.r_data;
   assign S_AXI_RRESP_O   = s_reg.r_resp;
   assign TX_BUSY_O       = (s_reg.st != rpf_pkg::TX_IDLE);
   assign PAY_READY_O     = (s_reg.st == rpf_pkg::TX_PAY) && ser_idle &&
                            (s_reg.cnt != s_reg.eff);
   assign RX_PAY_LEN_O    = s_reg.rx_len;
   assign RX_ADDR_O       = s_reg.rx_addr;
   assign RX_ADDR_BYTES_O = s_reg.rx_abytes;
   assign RX_MSB_FIRST_O  = msb_first; // R4

   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (RST_I);

   sequence s_frame_start;
      (s_reg.st == rpf_pkg::TX_IDLE) && TX_START_I;
   endsequence
   sequence s_pay_end;
      (s_reg.st == rpf_pkg::TX_PAY) && (s_reg.cnt == s_reg.eff);
   endsequence

   a_rx_len_cut: assert property ( // R1
      1'b1 |=> (RX_PAY_LEN_O <= $past(max_len)))
      else $error("Receive payload count above maximum");
   a_tx_len_cut: assert property ( // R1
      s_pay_end |=> (s_reg.st == rpf_pkg::TX_DONE) && (s_reg.cnt <= max_len))
      else $error("Transmit payload count above maximum");
   a_rx_len_extra: assert property ( // R2
      ({1'b0, RX_LEN_I} + {1'b0, stat_len} <= {1'b0, max_len})
      |=> (RX_PAY_LEN_O == $past(RX_LEN_I) + $past(stat_len)))
      else $error("Static extra length not added");
   a_addr_size: assert property ( // R3
      (s_reg.st == rpf_pkg::TX_ADDR) && ser_idle && (s_reg.k == base_bytes)
      |=> (s_reg.st == rpf_pkg::TX_HDR0) && (s_reg.k == base_bytes + 3'h1))
      else $error("Address not base length plus one byte");
   a_order_follow: assert property ( // R4
      ser_load && (s_reg.st != rpf_pkg::TX_ADDR) |-> (ser_msb == msb_first))
      else $error("Field sent in wrong bit order");
   a_prefix_low: assert property ( // R5
      (RX_LADDR_I == 3'h1)
      |=> (RX_ADDR_O[7:0] == $past(s_reg.regs[rpf_pkg::IDX_PFX_LO][15:8])))
      else $error("Prefix 1 not from lane 1 of low register");
   a_prefix_high: assert property ( // R6
      (RX_LADDR_I == 3'h6)
      |=> (RX_ADDR_O[7:0] == $past(s_reg.regs[rpf_pkg::IDX_PFX_HI][23:16])))
      else $error("Prefix 6 not from lane 2 of high register");
   a_field_seq: assert property ( // R7
      s_frame_start |=> (s_reg.st == rpf_pkg::TX_ADDR) ##1
      (s_reg.st inside {rpf_pkg::TX_ADDR, rpf_pkg::TX_HDR0}))
      else $error("Frame did not open with the address");
endmodule
`default_nettype wire

// [sim/rpf_air_rx.sv]
// Far-side radio model: collects on-air bits, stalling at random
`timescale 1ns/1ps
`default_nettype none
module rpf_air_rx
(
   input  wire logic clk_i,
   input  wire logic bit_i,
   input  wire logic valid_i,
   output logic      ready_o
);
   logic got [$];  // Bits taken, in air order
   // One cycle in four stalled so the framer must hold each bit
   always @(posedge clk_i)
   begin
      if (valid_i && ready_o)
         got.push_back(bit_i);
      ready_o <= ($urandom % 4) != 0;
   end
endmodule
`default_nettype wire

// [sim/testbench.sv]
// Self-checking bench for the packet format block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [11:0] awa = 12'h000;
   logic [11:0] ara = 12'h000;
   logic [31:0] wd = 32'h00000000;
   logic        awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
   logic        st = 1'b0, pv = 1'b0;
   logic [2:0]  tla = 3'h0, rla = 3'h0;
   logic [7:0]  h0 = 8'h00, tl = 8'h00, h1 = 8'h00, rl = 8'h00, pd = 8'h00;
   logic        awr, wr, bv, arr, rv, busy, pr, bo, bvo, brdy, msb;
   logic [1:0]  bresp, rresp;
   logic [31:0] rd;
   logic [7:0]  rpl;
   logic [39:0] rad;
   logic [2:0]  rab;
   logic [7:0]  pbuf [8];   // Payload bytes offered per frame
   logic [31:0] rg [6];     // Shadow of the register bank
   logic        exp_q [$];  // Expected air bits
   int          num_errors = 0;
   int          comparisons = 0;
   int          pidx = 8;   // Next payload byte; 8 means none offered
   int          i, k;
   logic [11:0] ofs [6] = '{rpf_pkg::PKT_CFG0_OFS, rpf_pkg::PKT_CFG1_OFS,
      rpf_pkg::BASE0_OFS, rpf_pkg::BASE_ADDRESS_1_OFS, rpf_pkg::PFX_LO_OFS,
      rpf_pkg::PFX_HI_OFS};
   logic [31:0] msk [6] = '{rpf_pkg::CFG0_MASK, rpf_pkg::CFG1_MASK,
      32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF};

   rpf_packet_format dut
   (
      .REF_CLK_I(clk), .RST_I(rst),
      .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr),
      .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wv),
      .S_AXI_WREADY_O(wr), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv),
      .S_AXI_BREADY_I(bry), .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv),
      .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rd), .S_AXI_RRESP_O(rresp),
      .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rry), .TX_START_I(st),
      .TX_LADDR_I(tla), .TX_HDR0_I(h0), .TX_LEN_I(tl), .TX_HDR1_I(h1),
      .TX_BUSY_O(busy), .PAY_DATA_I(pd), .PAY_VALID_I(pv), .PAY_READY_O(pr),
      .BIT_O(bo), .BIT_VALID_O(bvo), .BIT_READY_I(brdy), .RX_LEN_I(rl),
      .RX_LADDR_I(rla), .RX_PAY_LEN_O(rpl), .RX_ADDR_O(rad),
      .RX_ADDR_BYTES_O(rab), .RX_MSB_FIRST_O(msb)
   );
   rpf_air_rx air (.clk_i(clk), .bit_i(bo), .valid_i(bvo), .ready_o(brdy));

   // 200 MHz clock
   always #2.5 clk = ~clk;

   // Payload source; restarts at byte 0 on each frame start
   always @(posedge clk)
   begin
      if (st)
         pidx = 0;
      else if (pv && pr)
         pidx++;
      pv <= pidx < 8;
      pd <= pbuf[pidx % 8];
   end

   // Verdict and end of run
   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // A wait ran out: count it and stop
   task automatic hang();
      num_errors++;
      tally_and_finish();
   endtask

   // Single comparison point
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Write; both channels offered together, released as each is taken
   task automatic axw(input logic [11:0] a, input logic [31:0] d,
                      output logic [1:0] r);
      int n;
      @(posedge clk);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bry <= 1'b1;
      for (n = 0; n < 50; n++)
      begin
         @(posedge clk);
         if (awr) awv <= 1'b0;
         if (wr) wv <= 1'b0;
         if (bv) break;
      end
      if (n == 50) hang();
      r = bresp;
      bry <= 1'b0;
   endtask

   // Read; ready held until the data arrives
   task automatic axr(input logic [11:0] a, output logic [31:0] d,
                      output logic [1:0] r);
      int n;
      @(posedge clk);
      ara <= a;
      arv <= 1'b1;
      rry <= 1'b1;
      for (n = 0; n < 50; n++)
      begin
         @(posedge clk);
         if (arr) arv <= 1'b0;
         if (rv) break;
      end
      if (n == 50) hang();
      d = rd;
      r = rresp;
      rry <= 1'b0;
   endtask

   task automatic wrc(input logic [11:0] a, input logic [31:0] d,
                      input logic [1:0] er);
      logic [1:0] r;
      axw(a, d, r);
      chk(r, er);
   endtask

   task automatic rdc(input logic [11:0] a, input logic [31:0] e,
                      input logic [1:0] er);
      logic [31:0] d;
      logic [1:0]  r;
      axr(a, d, r);
      chk(d, e);
      chk(r, er);
   endtask

   // Payload bytes after extra length and maximum clip
   function automatic int plen(input int len);
      int t = len + rg[1][15:8];
      return (t > rg[1][7:0]) ? rg[1][7:0] : t;
   endfunction

   // Base length as used, lengths below two behave as two
   function automatic int bb();
      return (rg[1][18:16] < 2) ? 2 : (rg[1][18:16] > 4) ? 4 : rg[1][18:16];
   endfunction

   // Base word above the prefix byte of a logical address
   function automatic logic [39:0] eaddr(input int la);
      logic [31:0] b = (la == 0) ? rg[2] : rg[3];
      logic [31:0] p = (la < 4) ? rg[4] : rg[5];
      return {b, p[8 * (la % 4) +: 8]};
   endfunction

   // Queue a field's bits in the expected air order
   task automatic put(input logic [7:0] v, input int n, input logic m);
      for (int j = 0; j < n; j++)
         exp_q.push_back(m ? v[n - 1 - j] : v[j]);
   endtask

   // One frame from start to idle, compared bit by bit
   task automatic frame();
      int n, la, l;
      logic [7:0]  a0, a1;
      logic [39:0] e;
      la = $urandom % 8;
      l = $urandom % 8;
      a0 = 8'($urandom);
      a1 = 8'($urandom);
      e = eaddr(la);
      exp_q.delete();
      air.got.delete();
      foreach (pbuf[j]) pbuf[j] = 8'($urandom);
      for (int j = 0; j < bb(); j++) put(e[8 + 8 * j +: 8], 8, 1'b0);
      put(e[7:0], 8, 1'b0);
      if (rg[0][8]) put(a0, 8, rg[1][24]);
      put(8'(l), rg[0][3:0] > 8 ? 8 : rg[0][3:0], rg[1][24]);
      put(a1, rg[0][19:16], rg[1][24]);
      for (int j = 0; j < plen(l); j++) put(pbuf[j], 8, rg[1][24]);
      @(posedge clk);
      st <= 1'b1;
      tla <= 3'(la);
      tl <= 8'(l);
      h0 <= a0;
      h1 <= a1;
      @(posedge clk);
      st <= 1'b0;
      for (n = 0; n < 3000; n++)
      begin
         @(posedge clk);
         if (busy === 1'b0) break;
      end
      if (n == 3000) hang();
      chk(air.got.size(), exp_q.size());
      foreach (exp_q[j])
         if (j < air.got.size()) chk(air.got[j], exp_q[j]);
   endtask

   // Main sequence
   initial
   begin
      void'($urandom(32'h8198));
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      for (i = 0; i < 6; i++) rdc(ofs[i], 32'h00000000, rpf_pkg::RESP_OKAY);
      rdc(12'h52C, 32'h00000000, rpf_pkg::RESP_SLVERR);
      $display("Test reset values done");
      for (i = 0; i < 6; i++)
      begin
         rg[i] = $urandom;
         wrc(ofs[i], rg[i], rpf_pkg::RESP_OKAY);
         rdc(ofs[i], rg[i] & msk[i], rpf_pkg::RESP_OKAY);
      end
      wrc(12'h52C, 32'h12345678, rpf_pkg::RESP_SLVERR);
      $display("Test register access done");
      for (k = 0; k < 4; k++)
      begin
         rg[0] = (k < 2) ? 32'h00030106 : 32'h0000000A;
         rg[1] = 32'((k % 2) << 24 | (k + 1) << 16 | 32'h0200 | (4 + k));
         for (i = 2; i < 6; i++) rg[i] = $urandom;
         for (i = 0; i < 6; i++) wrc(ofs[i], rg[i], rpf_pkg::RESP_OKAY);
         for (i = 0; i < 8; i++)
         begin
            @(posedge clk);
            rl <= 8'($urandom);
            rla <= 3'($urandom);
            repeat (2) @(posedge clk);
            chk(rpl, plen(rl));
            chk(rad, eaddr(rla));
            chk(rab, bb() + 1);
            chk(msb, rg[1][24]);
         end
         frame();
         $display("Test frame setting %0d done", k);
      end
      tally_and_finish();
   end
endmodule
`default_nettype wire
